// [hw/pnf_pkg.sv]
// Shared constants for the parallel NOR flash host controller.
// Assumes a byte-wide flash on an asynchronous bus, host clock 20 MHz.
package pnf_pkg;

  // Bus widths and sector layout
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 8;
  localparam int SECT_W      = 6;
  localparam int GROUP_W     = 5;
  localparam int NUM_GROUPS  = 18;
  localparam int SECT_LSB    = 16;
  localparam int LAST_SECTOR = 63;
  localparam int LAST_GROUP  = 17;

  // Clock and pin timing, times in ns
  localparam int CLK_NS  = 50;
  localparam int T_ACC_NS = 90;   // Read access time, least wait
  localparam int T_WP_NS  = 50;   // Write strobe low time
  localparam int T_RP_NS  = 500;  // Reset pulse width
  localparam int T_RH_NS  = 50;   // Reset high before next access
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC  = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC  = (T_RH_NS + CLK_NS - 1) / CLK_NS;

  // Command sequence addresses and data bytes
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h000aaa;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h000555;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_ERASE    = 8'h80;
  localparam logic [DATA_W-1:0] CMD_SECT_ERS = 8'h30;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERS = 8'h10;
  localparam logic [DATA_W-1:0] CMD_AUTOSEL  = 8'h90;
  localparam logic [DATA_W-1:0] CMD_EXIT     = 8'hf0;

  // Identification read address bits
  localparam int ID_REGION_BIT = 1;
  localparam int CODE_SEL_BIT  = 0;

  // Host operations
  typedef enum logic [3:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ERASE_SECTOR,
    OP_ERASE_ADD,
    OP_ERASE_CHIP,
    OP_ID_READ,
    OP_PROT_VERIFY,
    OP_EXIT,
    OP_HW_RESET
  } pnf_op_t;

endpackage

// [hw/pnf_sector_map.sv]
// Maps a flash byte address onto its 64KB sector and protection group.
// Assumes the six top address bits pick the sector.
`timescale 1ns/1ps
module pnf_sector_map
(
  input  wire logic [pnf_pkg::ADDR_W-1:0]  i_addr,
  output logic      [pnf_pkg::SECT_W-1:0]  o_sector_index,
  output logic      [pnf_pkg::GROUP_W-1:0] o_sector_group
);

  // Top bits select the sector
  assign o_sector_index = i_addr[pnf_pkg::ADDR_W-1:pnf_pkg::SECT_LSB];

  // Ends hold short groups, the middle groups four sectors
  always_comb
  begin
    if (o_sector_index == 6'h00)
      o_sector_group = 5'h00;
    else if (o_sector_index < 6'h04)
      o_sector_group = 5'h01;
    else if (o_sector_index == 6'(pnf_pkg::LAST_SECTOR))
      o_sector_group = 5'(pnf_pkg::LAST_GROUP);
    else
      o_sector_group = 5'(o_sector_index[5:2]) + 5'h01;
  end

endmodule // pnf_sector_map

// [hw/pnf_host_ctrl.sv]
// Host-side controller that drives a parallel NOR flash through its pins.
// Assumes flash pins and user requests are synchronous to i_sys_clk.
// Functional notes
// - Host reads with chip select and output gate both low.
// - Write strobe stays high during reads.
// - Host writes with write strobe and chip select low, gate high.
// - Fast-program level only during accelerated programming.
`timescale 1ns/1ps
module pnf_host_ctrl
#(
  parameter int ADDR_W = pnf_pkg::ADDR_W,
  parameter int DATA_W = pnf_pkg::DATA_W
)
(
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_req,
  input  wire pnf_pkg::pnf_op_t           i_op,
  input  wire logic [ADDR_W-1:0]          i_addr,
  input  wire logic [DATA_W-1:0]          i_wdata,
  input  wire logic                       i_fast_en,
  input  wire logic                       i_temp_unprotect,
  input  wire logic [pnf_pkg::NUM_GROUPS-1:0] i_group_protected,
  input  wire logic [DATA_W-1:0]          i_dq,
  output logic                            o_busy,
  output logic                            o_ack,
  output logic                            o_refused,
  output logic      [DATA_W-1:0]          o_rdata,
  output logic      [ADDR_W-1:0]          o_addr,
  output logic      [DATA_W-1:0]          o_dq,
  output logic                            o_dq_oe,
  output logic                            o_ce_n,
  output logic                            o_oe_n,
  output logic                            o_we_n,
  output logic                            o_rst_n,
  output logic                            o_fast_program_pin,
  output logic                            o_protect_hv_en
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_WE, ST_HOLD, ST_GAP, ST_RD, ST_CAP, ST_RST, ST_REC
  } pnf_state_t;

  pnf_state_t       state_ff, nxt_state;
  pnf_pkg::pnf_op_t op_ff, cur_op;
  logic [2:0]       step_ff, nxt_step;
  logic [7:0]       cnt_ff, nxt_cnt;
  logic [ADDR_W-1:0] addr_ff, cur_addr, seq_addr;
  logic [DATA_W-1:0] wdata_ff, cur_wdata, seq_data;
  logic             boot_ff;
  logic             accept, prot_block;
  logic [pnf_pkg::SECT_W-1:0]  sect_idx;
  logic [pnf_pkg::GROUP_W-1:0] sect_grp;

  // Sector and group of the requested address
  pnf_sector_map pnf_sector_map_i
  (
    .i_addr         (i_addr),
    .o_sector_index (sect_idx),
    .o_sector_group (sect_grp)
  );

  // Number of command writes each operation needs
  function automatic logic [2:0] seq_len(input pnf_pkg::pnf_op_t op);
    unique case (op)
      pnf_pkg::OP_PROGRAM:      seq_len = 3'd4;
      pnf_pkg::OP_ERASE_SECTOR: seq_len = 3'd6;
      pnf_pkg::OP_ERASE_CHIP:   seq_len = 3'd6;
      pnf_pkg::OP_ERASE_ADD:    seq_len = 3'd1;
      pnf_pkg::OP_ID_READ:      seq_len = 3'd3;
      pnf_pkg::OP_PROT_VERIFY:  seq_len = 3'd3;
      pnf_pkg::OP_EXIT:         seq_len = 3'd1;
      default:                  seq_len = 3'd0;
    endcase
  endfunction

  // Operations that end with a read cycle
  function automatic logic has_read(input pnf_pkg::pnf_op_t op);
    has_read = (op == pnf_pkg::OP_READ) || (op == pnf_pkg::OP_ID_READ) ||
               (op == pnf_pkg::OP_PROT_VERIFY);
  endfunction

  // Operations that alter the array
  function automatic logic is_modify(input pnf_pkg::pnf_op_t op);
    is_modify = (op == pnf_pkg::OP_PROGRAM) ||
                (op == pnf_pkg::OP_ERASE_SECTOR) ||
                (op == pnf_pkg::OP_ERASE_ADD) ||
                (op == pnf_pkg::OP_ERASE_CHIP);
  endfunction

  // Refuse writes aimed at a protected group unless lifted
  always_comb
  begin
    prot_block = 1'b0;
    if (is_modify(i_op) && !i_temp_unprotect)
    begin
      if (i_op == pnf_pkg::OP_ERASE_CHIP)
        prot_block = |i_group_protected;
      else
        prot_block = i_group_protected[sect_grp];
    end
  end

  assign accept = (state_ff == ST_IDLE) && i_req && !boot_ff;
  assign cur_op    = accept ? i_op    : op_ff;
  assign cur_addr  = accept ? i_addr  : addr_ff;
  assign cur_wdata = accept ? i_wdata : wdata_ff;

  // Address and data of each write in a command sequence
  always_comb
  begin
    seq_addr = pnf_pkg::UNLOCK_ADDR1;
    seq_data = pnf_pkg::UNLOCK_DATA1;
    if (cur_op == pnf_pkg::OP_EXIT)
      seq_data = pnf_pkg::CMD_EXIT;
    else if (cur_op == pnf_pkg::OP_ERASE_ADD)
    begin
      seq_addr = cur_addr;
      seq_data = pnf_pkg::CMD_SECT_ERS;
    end
    else
    begin
      unique case (nxt_step)
        3'd1, 3'd4:
        begin
          seq_addr = pnf_pkg::UNLOCK_ADDR2;
          seq_data = pnf_pkg::UNLOCK_DATA2;
        end
        3'd2:
          if (cur_op == pnf_pkg::OP_PROGRAM)
            seq_data = pnf_pkg::CMD_PROGRAM;
          else if (is_modify(cur_op))
            seq_data = pnf_pkg::CMD_ERASE;
          else
            seq_data = pnf_pkg::CMD_AUTOSEL;
        3'd3:
          if (cur_op == pnf_pkg::OP_PROGRAM)
          begin
            seq_addr = cur_addr;
            seq_data = cur_wdata;
          end
        3'd5:
          if (cur_op == pnf_pkg::OP_ERASE_CHIP)
            seq_data = pnf_pkg::CMD_CHIP_ERS;
          else
          begin
            seq_addr = cur_addr;
            seq_data = pnf_pkg::CMD_SECT_ERS;
          end
        default:
          seq_data = pnf_pkg::UNLOCK_DATA1;
      endcase
    end
  end

  // Next state of the bus sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_IDLE:
        if (accept)
        begin
          nxt_step = 3'd0;
          nxt_cnt  = 8'h00;
          if (i_op == pnf_pkg::OP_HW_RESET)
            nxt_state = ST_RST;
          else if (prot_block)
            nxt_state = ST_IDLE;
          else if (seq_len(i_op) != 3'd0)
            nxt_state = ST_SETUP;
          else
            nxt_state = ST_RD;
        end
      ST_SETUP:
      begin
        nxt_state = ST_WE;
        nxt_cnt   = 8'h00;
      end
      ST_WE:
        if (cnt_ff == 8'(pnf_pkg::WP_CYC - 1))
          nxt_state = ST_HOLD;
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_HOLD:
        nxt_state = ST_GAP;
      ST_GAP:
        if (step_ff != seq_len(op_ff) - 3'd1)
        begin
          nxt_state = ST_SETUP;
          nxt_step  = step_ff + 3'd1;
        end
        else if (has_read(op_ff))
        begin
          nxt_state = ST_RD;
          nxt_cnt   = 8'h00;
        end
        else
          nxt_state = ST_IDLE;
      ST_RD:
        if (cnt_ff == 8'(pnf_pkg::ACC_CYC - 1))
          nxt_state = ST_CAP;
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_CAP:
        nxt_state = ST_IDLE;
      ST_RST:
        if (cnt_ff == 8'(pnf_pkg::RP_CYC - 1))
        begin
          nxt_state = ST_REC;
          nxt_cnt   = 8'h00;
        end
        else
          nxt_cnt = cnt_ff + 8'h01;
      ST_REC:
        if (cnt_ff == 8'(pnf_pkg::RH_CYC - 1))
          nxt_state = ST_IDLE;
        else
          nxt_cnt = cnt_ff + 8'h01;
    endcase
  end

  // Sequencer registers; reset pulses the flash back to array read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_ff <= ST_RST;
      step_ff  <= 3'd0;
      cnt_ff   <= 8'h00;
      boot_ff  <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      step_ff  <= nxt_step;
      cnt_ff   <= nxt_cnt;
      if (state_ff == ST_REC && nxt_state == ST_IDLE)
        boot_ff <= 1'b0;
    end
  end

  // Latched request
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      op_ff    <= pnf_pkg::OP_READ;
      addr_ff  <= '0;
      wdata_ff <= '0;
    end
    else if (accept)
    begin
      op_ff    <= i_op;
      addr_ff  <= i_addr;
      wdata_ff <= i_wdata;
    end
  end

  // Flash pins, registered from the next state
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
      o_dq_oe <= 1'b0;
      o_rst_n <= 1'b0;
      o_addr  <= '0;
      o_dq    <= '0;
    end
    else
    begin
      o_ce_n  <= !(nxt_state inside {ST_SETUP, ST_WE, ST_HOLD, ST_RD, ST_CAP});
      o_oe_n  <= !(nxt_state inside {ST_RD, ST_CAP});
      o_we_n  <= (nxt_state != ST_WE);
      o_dq_oe <= nxt_state inside {ST_SETUP, ST_WE, ST_HOLD};
      o_rst_n <= (nxt_state != ST_RST);
      if (nxt_state inside {ST_SETUP, ST_WE, ST_HOLD})
      begin
        o_addr <= seq_addr;
        o_dq   <= seq_data;
      end
      else if (nxt_state == ST_RD)
      begin
        o_addr <= cur_addr;
        if (cur_op == pnf_pkg::OP_ID_READ)
        begin
          o_addr <= '0;
          o_addr[pnf_pkg::CODE_SEL_BIT] <= cur_addr[pnf_pkg::CODE_SEL_BIT];
        end
        else if (cur_op == pnf_pkg::OP_PROT_VERIFY)
        begin
          o_addr <= '0;
          o_addr[ADDR_W-1:pnf_pkg::SECT_LSB] <=
            cur_addr[ADDR_W-1:pnf_pkg::SECT_LSB];
          o_addr[pnf_pkg::ID_REGION_BIT] <= 1'b1;
        end
      end
    end
  end

  // High-voltage requests: fast pin only while programming
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_fast_program_pin <= 1'b0;
      o_protect_hv_en    <= 1'b0;
    end
    else
    begin
      o_fast_program_pin <= i_fast_en && (cur_op == pnf_pkg::OP_PROGRAM) &&
        (nxt_state inside {ST_SETUP, ST_WE, ST_HOLD, ST_GAP});
      o_protect_hv_en    <= i_temp_unprotect && (nxt_state != ST_RST);
    end
  end

  // User answers; read data sampled at the end of the access
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_ack     <= 1'b0;
      o_refused <= 1'b0;
      o_busy    <= 1'b1;
      o_rdata   <= '0;
    end
    else
    begin
      o_ack     <= (state_ff != ST_IDLE) && (nxt_state == ST_IDLE) &&
                   !boot_ff;
      o_refused <= accept && prot_block &&
                   (i_op != pnf_pkg::OP_HW_RESET);
      o_busy    <= (nxt_state != ST_IDLE) || boot_ff;
      if (state_ff == ST_CAP)
        o_rdata <= i_dq;
    end
  end

  // Checks on the pins the controller drives
  sequence s_write_pulse;
    !o_ce_n && !o_we_n ##1 o_we_n && !o_ce_n;
  endsequence

  a_read_strobes: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
    else $error("read gate without select or with strobe");
  a_write_strobes: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
    else $error("write strobe with bad select or gate");
  a_we_first_up: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_we_n) |-> s_write_pulse ##1 o_ce_n)
    else $error("strobe not released before select");
  a_read_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_oe_n) |-> !o_oe_n [*3] ##1 o_oe_n)
    else $error("read access not three cycles");
  a_reset_width: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_rst_n) |-> (!o_rst_n && o_ce_n && o_we_n) [*8])
    else $error("flash reset pulse short or bus active");
  a_fast_only_prog: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_fast_program_pin |-> op_ff == pnf_pkg::OP_PROGRAM && !o_oe_n == 1'b0)
    else $error("fast level outside programming");
  a_refuse_protect: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    accept && prot_block && is_modify(i_op) |=> o_refused && !o_busy
      ##1 o_we_n)
    else $error("protected write not refused");
  a_id_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_oe_n && op_ff == pnf_pkg::OP_ID_READ |->
      !o_addr[pnf_pkg::ID_REGION_BIT])
    else $error("id read with region bit set");
  a_verify_addr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !o_oe_n && op_ff == pnf_pkg::OP_PROT_VERIFY |->
      o_addr[pnf_pkg::ID_REGION_BIT] && !o_addr[pnf_pkg::CODE_SEL_BIT])
    else $error("verify read address wrong");

endmodule // pnf_host_ctrl

// [sim/pnf_flash_model.sv]
// Behavioural model of the byte-wide flash that the host controller drives.
// Assumes pins from the controller; the bench resolves the shared data bus.
`timescale 1ns/1ps
module pnf_flash_model
#(
  parameter logic [7:0] MFR_CODE = 8'h5e,  // Arbitrary maker code
  parameter logic [7:0] DEV_CODE = 8'h7b   // Arbitrary device code
)
(
  input  wire logic [21:0] i_addr,
  input  wire logic [7:0]  i_d,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic        i_rst_n,
  input  wire logic        i_acc,
  input  wire logic        i_hv,
  input  wire logic [17:0] i_prot,
  output logic      [7:0]  o_q,
  output logic             o_q_en,
  output int               o_fast_cnt
);
  logic [7:0] mem [int];
  int         step = 0;
  logic       prog_arm = 0;
  logic       ers_arm = 0;
  logic       keep;
  logic       id_mode = 0;
  logic [7:0] rv;
  // Write strobe ends at whichever of select or strobe rises first
  wire wr_stb = !i_ce_n && !i_we_n && i_oe_n && i_rst_n;

  // Sector to protection group
  function automatic int grp(input int s);
    return (s == 0) ? 0 : (s < 4) ? 1 : (s == 63) ? 17 : s / 4 + 1;
  endfunction

  // Protected unless the high voltage sits on the reset pin
  function automatic logic locked(input logic [21:0] a);
    return i_prot[grp(int'(a[21:16]))] && !i_hv;
  endfunction

  // Erase one sector unless protected
  task automatic ers(input int s);
    int ks[$];
    if (i_prot[grp(s)] && !i_hv) return;
    foreach (mem[k]) if ((k >> 16) == s) ks.push_back(k);
    foreach (ks[i]) mem.delete(ks[i]);
  endtask

  // Command decoder; any unexpected write falls back to array read
  always @(negedge wr_stb)
  begin
    keep = ers_arm;
    ers_arm = 0;
    if (!i_rst_n) step = 0;
    else if (prog_arm)
    begin
      prog_arm = 0;
      if (!locked(i_addr))
      begin
        mem[i_addr] = (mem.exists(i_addr) ? mem[i_addr] : 8'hff) & i_d;
        if (i_acc) o_fast_cnt++;
      end
    end
    else if (keep && i_d == 8'h30)
    begin
      ers(int'(i_addr[21:16]));
      ers_arm = 1;
    end
    else if ((step == 0 || step == 3) && i_addr[11:0] == 12'haaa
             && i_d == 8'haa) step = step + 1;
    else if ((step == 1 || step == 4) && i_addr[11:0] == 12'h555
             && i_d == 8'h55) step = step + 1;
    else if (step == 2 && i_addr[11:0] == 12'haaa && i_d == 8'ha0)
    begin
      prog_arm = 1;
      step = 0;
    end
    else if (step == 2 && i_addr[11:0] == 12'haaa && i_d == 8'h80) step = 3;
    else if (step == 2 && i_addr[11:0] == 12'haaa && i_d == 8'h90)
    begin
      id_mode = 1;
      step = 0;
    end
    else if (step == 5 && i_d == 8'h30)
    begin
      ers(int'(i_addr[21:16]));
      ers_arm = 1;
      step = 0;
    end
    else if (step == 5 && i_addr[11:0] == 12'haaa && i_d == 8'h10)
    begin
      for (int s = 0; s < 64; s++) ers(s);
      step = 0;
    end
    else
    begin
      step = 0;
      id_mode = 0;
    end
  end

  // Reset pin low aborts everything and returns to array read
  always @(i_rst_n)
  begin
    if (!i_rst_n)
    begin
      step = 0;
      prog_arm = 0;
      ers_arm = 0;
      id_mode = 0;
    end
  end

  // Read path; data settles after the access time, junk before it
  always @(i_addr or i_ce_n or i_oe_n or i_rst_n or id_mode or i_prot)
  begin
    if (id_mode)
      rv = i_addr[1] ? {7'h00, i_prot[grp(int'(i_addr[21:16]))]}
                     : (i_addr[0] ? DEV_CODE : MFR_CODE);
    else
      rv = mem.exists(i_addr) ? mem[i_addr] : 8'hff;
    o_q_en = !i_ce_n && !i_oe_n && i_rst_n;
    o_q = ~rv;
    o_q <= #60 rv;
  end

  initial o_fast_cnt = 0;
endmodule // pnf_flash_model

// [sim/parallel_nor_flash_bus_interface_tb_top.sv]
// Self-checking bench for the flash host controller with a flash model.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module parallel_nor_flash_bus_interface_tb_top;
  logic        clk = 0;
  logic        i_rst = 1;
  logic        i_req = 0;
  logic        i_fast_en = 0;
  logic        i_temp_unprotect = 0;
  pnf_pkg::pnf_op_t i_op = pnf_pkg::OP_READ;
  logic [21:0] i_addr = '0;
  logic [7:0]  i_wdata = '0;
  logic [17:0] prot = '0;
  logic [7:0]  dq_last = '0;
  logic [7:0]  q;
  logic        q_en;
  int          fast_cnt;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic        busy, ack, refd, dq_oe, ce_n, oe_n, we_n, rst_n, acc, hv;
  logic [7:0]  rdata, o_dq;
  logic [21:0] f_addr;
  wire  [7:0]  i_dq = dq_oe ? o_dq : (q_en ? q : ~dq_last);

  pnf_host_ctrl pnf_host_ctrl_i (.i_sys_clk(clk), .i_rst(i_rst),
    .i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_fast_en(i_fast_en), .i_temp_unprotect(i_temp_unprotect),
    .i_group_protected(prot), .i_dq(i_dq), .o_busy(busy), .o_ack(ack),
    .o_refused(refd), .o_rdata(rdata), .o_addr(f_addr), .o_dq(o_dq),
    .o_dq_oe(dq_oe), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_rst_n(rst_n), .o_fast_program_pin(acc), .o_protect_hv_en(hv));
  pnf_flash_model pnf_flash_model_i (.i_addr(f_addr), .i_d(i_dq),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(rst_n),
    .i_acc(acc), .i_hv(hv), .i_prot(prot), .o_q(q), .o_q_en(q_en),
    .o_fast_cnt(fast_cnt));

  // Clock, and a released data line that changes every cycle
  initial forever #25 clk = ~clk;
  always @(posedge clk) dq_last <= i_dq;

  // Pin sanity sampled away from the launching edge
  always @(negedge clk)
  begin
    if (!i_rst && oe_n === 1'b0 && we_n !== 1'b1) bad("strobe in read");
    if (!i_rst && oe_n === 1'b0 && dq_oe !== 1'b0) bad("bus fight");
    if (!i_rst && oe_n === 1'b0 && acc !== 1'b0) bad("fast pin in read");
    if (!i_rst && oe_n === 1'b0 && ce_n !== 1'b0) bad("no select");
  end

  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) bad($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  // One user request; reports ack and reset-pin low cycles
  task automatic do_op(input pnf_pkg::pnf_op_t op, input logic [21:0] a,
                       input logic [7:0] d, output logic ok, output int lo);
    int n;
    n = 0;
    lo = 0;
    @(negedge clk);
    i_req = 1;
    i_op = op;
    i_addr = a;
    i_wdata = d;
    @(negedge clk);
    i_req = 0;
    while (ack !== 1'b1 && refd !== 1'b1)
    begin
      if (rst_n === 1'b0) lo++;
      if (++n > 400)
      begin
        bad("no answer");
        final_report();
      end
      @(negedge clk);
    end
    ok = (ack === 1'b1);
  endtask

  // Request that must be acknowledged, optionally checking the read byte
  task automatic run(input pnf_pkg::pnf_op_t op, input logic [21:0] a,
                     input logic [7:0] d, input logic [7:0] exp, input int c);
    logic ok;
    int lo;
    do_op(op, a, d, ok, lo);
    chk({7'h00, ok}, 8'h01, "ack");
    if (c) chk(rdata, exp, "rdata");
  endtask

  task automatic t_boot();
    int n;
    @(negedge clk);
    chk({7'h00, rst_n}, 8'h00, "boot pulse");
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk);
    if (busy !== 1'b0)
    begin
      bad("boot hang");
      final_report();
    end
    chk({7'h00, rst_n}, 8'h01, "boot release");
    run(pnf_pkg::OP_READ, 22'h000100, 8'h00, 8'hff, 1);
  endtask

  task automatic t_program();
    run(pnf_pkg::OP_PROGRAM, 22'h3f1234, 8'h5a, 8'h00, 0);
    run(pnf_pkg::OP_READ, 22'h3f1234, 8'h00, 8'h5a, 1);
    run(pnf_pkg::OP_READ, 22'h3e1234, 8'h00, 8'hff, 1);
    i_fast_en = 1;
    run(pnf_pkg::OP_PROGRAM, 22'h3f1235, 8'ha5, 8'h00, 0);
    i_fast_en = 0;
    chk(8'(fast_cnt), 8'h01, "fast count");
    run(pnf_pkg::OP_READ, 22'h3f1235, 8'h00, 8'ha5, 1);
  endtask

  task automatic t_ident();
    run(pnf_pkg::OP_ID_READ, 22'h000000, 8'h00, 8'h5e, 1);
    run(pnf_pkg::OP_ID_READ, 22'h000001, 8'h00, 8'h7b, 1);
    run(pnf_pkg::OP_EXIT, 22'h000000, 8'h00, 8'h00, 0);
    run(pnf_pkg::OP_READ, 22'h3f1234, 8'h00, 8'h5a, 1);
  endtask

  task automatic t_protect();
    logic ok;
    int lo;
    prot = 18'h10000;
    run(pnf_pkg::OP_PROT_VERIFY, 22'h3c0000, 8'h00, 8'h01, 1);
    run(pnf_pkg::OP_PROT_VERIFY, 22'h3e0000, 8'h00, 8'h01, 1);
    run(pnf_pkg::OP_PROT_VERIFY, 22'h3b0000, 8'h00, 8'h00, 1);
    run(pnf_pkg::OP_PROT_VERIFY, 22'h3f0000, 8'h00, 8'h00, 1);
    run(pnf_pkg::OP_EXIT, 22'h000000, 8'h00, 8'h00, 0);
    do_op(pnf_pkg::OP_PROGRAM, 22'h3e0010, 8'h00, ok, lo);
    chk({7'h00, ok}, 8'h00, "protected program");
    do_op(pnf_pkg::OP_ERASE_CHIP, 22'h000000, 8'h00, ok, lo);
    chk({7'h00, ok}, 8'h00, "protected chip erase");
    i_temp_unprotect = 1;
    run(pnf_pkg::OP_PROGRAM, 22'h3e0010, 8'h00, 8'h00, 0);
    chk({7'h00, hv}, 8'h01, "protect voltage on");
    i_temp_unprotect = 0;
    run(pnf_pkg::OP_READ, 22'h3e0010, 8'h00, 8'h00, 1);
    chk({7'h00, hv}, 8'h00, "protect voltage off");
    do_op(pnf_pkg::OP_PROGRAM, 22'h3e0020, 8'h00, ok, lo);
    chk({7'h00, ok}, 8'h00, "protection restored");
    prot = '0;
  endtask

  task automatic t_reset();
    logic ok;
    int lo;
    run(pnf_pkg::OP_ID_READ, 22'h000000, 8'h00, 8'h5e, 1);
    do_op(pnf_pkg::OP_HW_RESET, 22'h000000, 8'h00, ok, lo);
    chk(8'(lo), 8'(pnf_pkg::RP_CYC), "reset low cycles");
    run(pnf_pkg::OP_READ, 22'h3e0010, 8'h00, 8'h00, 1);
  endtask

  task automatic t_erase();
    run(pnf_pkg::OP_PROGRAM, 22'h000010, 8'h12, 8'h00, 0);
    run(pnf_pkg::OP_PROGRAM, 22'h010010, 8'h34, 8'h00, 0);
    run(pnf_pkg::OP_ERASE_SECTOR, 22'h000000, 8'h00, 8'h00, 0);
    run(pnf_pkg::OP_ERASE_ADD, 22'h010000, 8'h00, 8'h00, 0);
    run(pnf_pkg::OP_READ, 22'h000010, 8'h00, 8'hff, 1);
    run(pnf_pkg::OP_READ, 22'h010010, 8'h00, 8'hff, 1);
    run(pnf_pkg::OP_READ, 22'h3f1234, 8'h00, 8'h5a, 1);
    run(pnf_pkg::OP_ERASE_CHIP, 22'h000000, 8'h00, 8'h00, 0);
    run(pnf_pkg::OP_READ, 22'h3f1234, 8'h00, 8'hff, 1);
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    i_rst = 0;
    t_boot();
    t_program();
    t_ident();
    t_protect();
    t_reset();
    t_erase();
    final_report();
  end
endmodule // parallel_nor_flash_bus_interface_tb_top
